// *** rtl/gain_link_defines.vh ***
// Purpose: Shared constants for the gain link matrix
// Assumes: Gain reduction is an unsigned 24-bit magnitude, larger means more reduction
// Notes: Definitions only
`ifndef GAIN_LINK_DEFINES_VH
`define GAIN_LINK_DEFINES_VH
// Register offsets (word addresses on the plain port)
`define ADDR_ASSIGN 4'h0
`define ADDR_PRIV_XLINK 4'h1
`define ADDR_PUB_XLINK 4'h2
`define ADDR_CTRL 4'h3
`define ADDR_STATUS 4'h4
`define ADDR_PUB_A 4'h5
`define ADDR_PUB_B 4'h6
// Channel assignment codes, two bits per channel
`define ASG_BUS_A 2'h0
`define ASG_BUS_B 2'h1
`define ASG_ISOLATE 2'h2
`define ASG_OFF 2'h3
// Control field positions
`define CTRL_LINK_LO 0
`define CTRL_PUBLIC_LO 8
`define CTRL_ROLE_LSB 16
`define CTRL_SIZE_LSB 18
// External link roles
`define ROLE_OFF 2'h0
`define ROLE_MASTER 2'h1
`define ROLE_SLAVE 2'h2
// Group size codes
`define SIZE_4 2'h0
`define SIZE_6 2'h1
`define SIZE_8 2'h2
// Reset values
`define ASSIGN_RST 16'h0000
`define XLINK_RST 16'h0000
`define CTRL_RST 20'h00000
// Cross-link percentage full scale
`define PCT_FULL 7'h64
// Serial subframe: 24 data bits, one flag bit marking the right subframe
`define SUB_BITS 6'h19
// Link idle timeout in system clock cycles without a link clock rise
`define LINK_TIMEOUT_CYC 16'h1000
`endif

// *** rtl/bus_cross.v ***
// Purpose: Combine one link bus with scaled reduction from the other bus
// Assumes: Inputs are already the bus's own combined reduction for this sample
// Notes: Pure combinational, no state, so no feedback loop can form
`timescale 1ns/10ps
`include "gain_link_defines.vh"
module bus_cross #(
  parameter W = 24
) (
  input wire [W-1:0] own_gr,
  input wire [W-1:0] other_gr,
  input wire [6:0] pct,
  output wire [W-1:0] out_gr
);
  wire [W+6:0] prod;
  wire [W+6:0] scaled;
  wire [W-1:0] part;
  // Scale other bus by percent; clamp pct above full scale
  assign prod = other_gr * ((pct > `PCT_FULL) ? `PCT_FULL : pct);
  assign scaled = prod / `PCT_FULL;
  assign part = scaled[W-1:0];
  // Larger value wins: scaled part only acts where own reduction is smaller
  assign out_gr = (part > own_gr) ? part : own_gr;
endmodule // bus_cross

// *** rtl/gain_link_matrix.v ***
// Purpose: Gain reduction link matrix for one surround group plus public busses
// Assumes: Per-channel gain reduction arrives once per sample on smp_stb
// Notes: Register map and link framing live in the defines header
// Behaviour
// - Group of four, six or eight channels has two link busses A, B
// - After reset every channel sits on bus A
// - Bus members all get the largest member reduction
// - Isolated channel keeps own reduction, feeds no bus
// - Off channel gets zero reduction, audio path unchanged
// - Percentage scales bus A into B, applied only where larger
// - Independent percentage scales bus B into A, same larger rule
// - Linking acts only while the channel link switch is on
// - Busses private by default, a setting makes them public
// - One public A and one public B bus shared across groups
// - Non-public stereo or mono channels link as adjacent pairs
// - One shared percentage set governs the public busses
// - Linked gain goes to group smoothing, identical within the group
// - Public gains exchanged over serial link; role off, master or slave
// - Units form a ring from master through slaves back to master
// - Units share a clock; slaves recover it from the link
// - Lone master looped back runs link and emits recordable data
// - Slave receiving recorded data applies it to its public bus
// - 24-bit normal audio words, bus A left, bus B right
// - Received data fully replaces internal reduction, still smoothed
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`include "gain_link_defines.vh"
module gain_link_matrix #(
  parameter NCH = 8,
  parameter W = 24,
  parameter TIMEOUT = `LINK_TIMEOUT_CYC
) (
  input wire clk,
  input wire nrst,
  input wire [3:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [31:0] rdata,
  input wire smp_stb,
  input wire [NCH*W-1:0] chan_gr,
  input wire [2*W-1:0] peer_pub_in,
  output reg [NCH*W-1:0] smooth_gr,
  output reg smooth_stb,
  output reg [1:0] pub_use,
  input wire link_clk,
  input wire link_rx,
  output reg link_tx
);
  ////////////////////////////////////////////////////////////////////
  // Registers
  reg [15:0] assign_r;
  reg [15:0] priv_xlink_r;
  reg [15:0] pub_xlink_r;
  reg [19:0] ctrl_r;
  wire [1:0] role;
  wire [1:0] gsize;
  assign role = ctrl_r[`CTRL_ROLE_LSB+1:`CTRL_ROLE_LSB];
  assign gsize = ctrl_r[`CTRL_SIZE_LSB+1:`CTRL_SIZE_LSB];

  // group width; channels above it link as stereo or mono pairs
  reg [3:0] grp_n;
  always @*
  begin
    case (gsize)
      `SIZE_4: grp_n = 4'h4;
      `SIZE_6: grp_n = 4'h6;
      `SIZE_8: grp_n = 4'h8;
      default: grp_n = 4'h8;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // link clock sampled locally; two flops before any edge logic
  reg clk_s1_r, clk_s2_r, clk_s3_r;
  reg rx_s1_r, rx_s2_r;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      clk_s1_r <= 1'b0;
      clk_s2_r <= 1'b0;
      clk_s3_r <= 1'b0;
      rx_s1_r <= 1'b0;
      rx_s2_r <= 1'b0;
    end
    else
    begin
      clk_s1_r <= link_clk;
      clk_s2_r <= clk_s1_r;
      clk_s3_r <= clk_s2_r;
      rx_s1_r <= link_rx;
      rx_s2_r <= rx_s1_r;
    end
  end
  wire lk_rise;
  wire lk_fall;
  assign lk_rise = clk_s2_r & ~clk_s3_r;
  assign lk_fall = ~clk_s2_r & clk_s3_r;

  ////////////////////////////////////////////////////////////////////
  // Link receiver: 25-bit subframes, msb first; bit 24 set marks right
  reg [24:0] rx_sh_r;
  reg [5:0] rx_cnt_r;
  reg [W-1:0] rx_a_r;
  reg [W-1:0] rx_b_r;
  reg rx_valid_r;
  reg [15:0] idle_cnt_r;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_sh_r <= 25'h0;
      rx_cnt_r <= 6'h0;
      rx_a_r <= {W{1'b0}};
      rx_b_r <= {W{1'b0}};
      rx_valid_r <= 1'b0;
      idle_cnt_r <= 16'h0;
    end
    else
    begin
      // Timeout drops replay when the link clock stops
      if (lk_rise)
        idle_cnt_r <= 16'h0;
      else if (idle_cnt_r != TIMEOUT[15:0])
        idle_cnt_r <= idle_cnt_r + 16'h1;
      else
        rx_valid_r <= 1'b0;
      if (lk_rise)
      begin
        rx_sh_r <= {rx_sh_r[23:0], rx_s2_r};
        if (rx_cnt_r == `SUB_BITS - 6'h1)
        begin
          rx_cnt_r <= 6'h0;
          if (rx_sh_r[23])
          begin
            rx_b_r <= {rx_sh_r[22:0], rx_s2_r};
            rx_valid_r <= 1'b1;
          end
          else
            rx_a_r <= {rx_sh_r[22:0], rx_s2_r};
        end
        else
          rx_cnt_r <= rx_cnt_r + 6'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Per-sample combining
  reg [W-1:0] bus_a, bus_b, pub_a, pub_b;
  reg [W-1:0] own;
  reg [NCH*W-1:0] res;
  reg [NCH*W-1:0] pair_gr;
  reg [1:0] use_pub;
  reg [3:0] ci, cj;
  reg [W-1:0] pa, pb, cown, cbus;
  wire [W-1:0] xa, xb, pxa, pxb;
  wire slave_rx;
  assign slave_rx = (role == `ROLE_SLAVE) && rx_valid_r;

  always @*
  begin
    bus_a = {W{1'b0}};
    bus_b = {W{1'b0}};
    pub_a = {W{1'b0}};
    pub_b = {W{1'b0}};
    use_pub = 2'b00;
    pair_gr = {NCH*W{1'b0}};
    own = {W{1'b0}};
    for (ci = 4'h0; ci < NCH; ci = ci + 4'h1)
    begin
      own = chan_gr[ci*W +: W];
      // isolate feeds nothing; switch gates membership
      if (ci < grp_n && ctrl_r[`CTRL_LINK_LO] && assign_r[ci*2 +: 2] == `ASG_BUS_A)
      begin
        if (ctrl_r[`CTRL_PUBLIC_LO])
        begin
          pub_a = (own > pub_a) ? own : pub_a;
          use_pub[0] = 1'b1;
        end
        else
          bus_a = (own > bus_a) ? own : bus_a;
      end
      if (ci < grp_n && ctrl_r[`CTRL_LINK_LO] && assign_r[ci*2 +: 2] == `ASG_BUS_B)
      begin
        if (ctrl_r[`CTRL_PUBLIC_LO])
        begin
          pub_b = (own > pub_b) ? own : pub_b;
          use_pub[1] = 1'b1;
        end
        else
          bus_b = (own > bus_b) ? own : bus_b;
      end
    end
    pa = (peer_pub_in[W-1:0] > pub_a) ? peer_pub_in[W-1:0] : pub_a;
    pb = (peer_pub_in[2*W-1:W] > pub_b) ? peer_pub_in[2*W-1:W] : pub_b;
    if (slave_rx)
    begin
      pa = rx_a_r;
      pb = rx_b_r;
    end
    for (ci = 4'h0; ci < NCH; ci = ci + 4'h2)
    begin
      own = (chan_gr[ci*W +: W] > chan_gr[(ci+1)*W +: W]) ?
        chan_gr[ci*W +: W] : chan_gr[(ci+1)*W +: W];
      pair_gr[ci*W +: W] = own;
      pair_gr[(ci+1)*W +: W] = own;
    end
  end

  // A into B; B into A; no recursion
  bus_cross #(.W(W)) u_priv_b (.own_gr(bus_b), .other_gr(bus_a),
    .pct(priv_xlink_r[6:0]), .out_gr(xb));
  bus_cross #(.W(W)) u_priv_a (.own_gr(bus_a), .other_gr(bus_b),
    .pct(priv_xlink_r[14:8]), .out_gr(xa));
  bus_cross #(.W(W)) u_pub_b (.own_gr(pb), .other_gr(pa),
    .pct(pub_xlink_r[6:0]), .out_gr(pxb));
  bus_cross #(.W(W)) u_pub_a (.own_gr(pa), .other_gr(pb),
    .pct(pub_xlink_r[14:8]), .out_gr(pxa));

  // Final per-channel selection; own temporaries so the bus sums are never redriven here
  always @*
  begin
    res = {NCH*W{1'b0}};
    cbus = {W{1'b0}};
    for (cj = 4'h0; cj < NCH; cj = cj + 4'h1)
    begin
      cown = chan_gr[cj*W +: W];
      if (cj >= grp_n)
        res[cj*W +: W] = ctrl_r[`CTRL_LINK_LO + 1 + cj/2] ? pair_gr[cj*W +: W] : cown;
      else
      begin
        case (assign_r[cj*2 +: 2])
          `ASG_BUS_A: cbus = ctrl_r[`CTRL_PUBLIC_LO] ? pxa : xa;
          `ASG_BUS_B: cbus = ctrl_r[`CTRL_PUBLIC_LO] ? pxb : xb;
          default: cbus = {W{1'b0}};
        endcase
        if (assign_r[cj*2 +: 2] == `ASG_OFF)
          res[cj*W +: W] = {W{1'b0}};
        else if (ctrl_r[`CTRL_LINK_LO] && assign_r[cj*2 +: 2] != `ASG_ISOLATE)
          res[cj*W +: W] = (slave_rx && ctrl_r[`CTRL_PUBLIC_LO]) ? cbus :
            ((cbus > cown) ? cbus : cown);
        else
          res[cj*W +: W] = cown;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sample registers toward smoothing; one strobe for the whole group
  reg [W-1:0] tx_a_r, tx_b_r;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      smooth_gr <= {NCH*W{1'b0}};
      smooth_stb <= 1'b0;
      pub_use <= 2'b00;
      tx_a_r <= {W{1'b0}};
      tx_b_r <= {W{1'b0}};
    end
    else
    begin
      smooth_stb <= smp_stb;
      if (smp_stb)
      begin
        smooth_gr <= res;
        pub_use <= use_pub;
        tx_a_r <= pa;
        tx_b_r <= pb;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Link transmitter: role; ring output; master emits data
  reg [24:0] tx_sh_r;
  reg [5:0] tx_cnt_r;
  reg tx_right_r;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_sh_r <= 25'h0;
      tx_cnt_r <= 6'h0;
      tx_right_r <= 1'b0;
      link_tx <= 1'b0;
    end
    else if (role == `ROLE_OFF)
    begin
      link_tx <= 1'b0;
      tx_cnt_r <= 6'h0;
    end
    else if (lk_fall)
    begin
      if (tx_cnt_r == 6'h0)
      begin
        link_tx <= 1'b0 ^ tx_right_r;
        tx_sh_r <= {1'b0, tx_right_r ? pxb : pxa};
        tx_right_r <= ~tx_right_r;
        tx_cnt_r <= 6'h1;
      end
      else
      begin
        link_tx <= tx_sh_r[W-1];
        tx_sh_r <= {tx_sh_r[23:0], 1'b0};
        tx_cnt_r <= (tx_cnt_r == `SUB_BITS - 6'h1) ? 6'h0 : tx_cnt_r + 6'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register port; reset puts all channels on bus A
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      assign_r <= `ASSIGN_RST;
      priv_xlink_r <= `XLINK_RST;
      pub_xlink_r <= `XLINK_RST;
      ctrl_r <= `CTRL_RST;
      rdata <= 32'h0;
    end
    else
    begin
      if (wr_stb)
      begin
        case (addr)
          `ADDR_ASSIGN: assign_r <= wdata[15:0];
          `ADDR_PRIV_XLINK: priv_xlink_r <= wdata[15:0];
          `ADDR_PUB_XLINK: pub_xlink_r <= wdata[15:0];
          `ADDR_CTRL: ctrl_r <= wdata[19:0];
          default: ;
        endcase
      end
      rdata <= 32'h0;
      if (rd_stb)
      begin
        case (addr)
          `ADDR_ASSIGN: rdata <= {16'h0, assign_r};
          `ADDR_PRIV_XLINK: rdata <= {16'h0, priv_xlink_r};
          `ADDR_PUB_XLINK: rdata <= {16'h0, pub_xlink_r};
          `ADDR_CTRL: rdata <= {12'h0, ctrl_r};
          `ADDR_STATUS: rdata <= {29'h0, rx_valid_r, use_pub};
          `ADDR_PUB_A: rdata <= {{(32-W){1'b0}}, tx_a_r};
          `ADDR_PUB_B: rdata <= {{(32-W){1'b0}}, tx_b_r};
          default: rdata <= 32'h0;
        endcase
      end
    end
  end
endmodule // gain_link_matrix

// *** verif/gain_link_matrix_asserts.sv ***
// Purpose: Port checks for the gain link matrix
// Assumes: Shadows of ASSIGN and CTRL follow software writes
// Notes: Per-channel checks watch channels 0 and 1 only, to stay small
`timescale 1ns/10ps
`include "gain_link_defines.vh"
module gain_link_matrix_asserts #(
  parameter NCH = 8,
  parameter W = 24,
  parameter TIMEOUT = 16'h1000
) (
  input wire clk,
  input wire nrst,
  input wire [3:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  input wire [31:0] rdata,
  input wire smp_stb,
  input wire [NCH*W-1:0] chan_gr,
  input wire [NCH*W-1:0] smooth_gr,
  input wire smooth_stb
);
  reg [15:0] asg_r;
  reg [19:0] ctl_r;
  wire [W-1:0] own0 = chan_gr[W-1:0];
  wire [W-1:0] own1 = chan_gr[2*W-1:W];
  wire [W-1:0] out0 = smooth_gr[W-1:0];
  wire [W-1:0] out1 = smooth_gr[2*W-1:W];
  wire [1:0] a0 = asg_r[1:0];
  wire [1:0] a1 = asg_r[3:2];
  wire slave = ctl_r[17:16] == `ROLE_SLAVE;
  // Shadow the mode registers; the design updates its own on the same edge
  always @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      asg_r <= `ASSIGN_RST;
      ctl_r <= `CTRL_RST;
    end
    else if (wr_stb && addr == `ADDR_ASSIGN)
      asg_r <= wdata[15:0];
    else if (wr_stb && addr == `ADDR_CTRL)
      ctl_r <= wdata[19:0];
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_quiet;
    !smp_stb ##1 !smp_stb;
  endsequence
  property p_stb; smp_stb |=> smooth_stb; endproperty
  property p_stb_only; smooth_stb |-> $past(smp_stb); endproperty
  property p_hold; s_quiet |=> $stable(smooth_gr); endproperty
  property p_off; smp_stb && a0 == `ASG_OFF |=> out0 == 0; endproperty
  property p_iso; smp_stb && a1 == `ASG_ISOLATE |=> out1 == $past(own1); endproperty
  property p_unlinked;
    smp_stb && !ctl_r[0] && !ctl_r[1] && !ctl_r[8] && a0 != `ASG_OFF |=> out0 == $past(own0);
  endproperty
  property p_floor; smp_stb && a0 != `ASG_OFF && !slave |=> out0 >= $past(own0); endproperty
  property p_equal;
    smp_stb && ctl_r[0] && a0 == `ASG_BUS_A && a1 == `ASG_BUS_A && !slave |=> out0 == out1;
  endproperty
  property p_rd_zero; !rd_stb |=> rdata == 32'h0; endproperty
  property p_rd_ctl; rd_stb && addr == `ADDR_CTRL |=> rdata[19:0] == $past(ctl_r); endproperty
  a_stb: assert property (p_stb) else $error("smooth_stb missing");
  a_stb_only: assert property (p_stb_only) else $error("stray smooth_stb");
  a_hold: assert property (p_hold) else $error("smooth_gr moved");
  a_off: assert property (p_off) else $error("off channel reduced");
  a_iso: assert property (p_iso) else $error("isolated channel wrong");
  a_unlinked: assert property (p_unlinked) else $error("unlinked channel wrong");
  a_floor: assert property (p_floor) else $error("below own reduction");
  a_equal: assert property (p_equal) else $error("bus members differ");
  a_rd_zero: assert property (p_rd_zero) else $error("rdata not idle");
  a_rd_ctl: assert property (p_rd_ctl) else $error("control readback");
endmodule // gain_link_matrix_asserts

bind gain_link_matrix gain_link_matrix_asserts #(.NCH(NCH), .W(W), .TIMEOUT(TIMEOUT)) u_chk (
  .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rdata(rdata), .smp_stb(smp_stb), .chan_gr(chan_gr), .smooth_gr(smooth_gr),
  .smooth_stb(smooth_stb));

// *** verif/peer_link_model.sv ***
// Purpose: Upstream ring peer sending gain frames
// Assumes: Link clock runs only within frames
// Notes: Data changes on the falling link edge
`timescale 1ns/10ps
module peer_link_model (
  output reg link_clk,
  output reg link_rx
);
  initial
  begin
    link_clk = 1'b0;
    link_rx = 1'b1;
  end
  // ring feed, clocked frame, A left then B right
  task send_frame(input [23:0] ga, input [23:0] gb);
    reg [49:0] bits;
    integer i;
    begin
      // Start clear of the bench clock edge
      #2;
      bits = {1'b0, ga, 1'b1, gb};
      for (i = 49; i >= 0; i = i - 1)
      begin
        link_rx = bits[i];
        #80 link_clk = 1'b1;
        #80 link_clk = 1'b0;
      end
      // Released line shows the inverse so a stale bit cannot pass
      link_rx = ~bits[0];
    end
  endtask
endmodule // peer_link_model

// *** verif/tb_gain_link_matrix.sv ***
// Purpose: Self-checking bench for the gain link matrix
// Assumes: Four-channel group plus one stereo pair, short link timeout
// Notes: Replay drop is timed from the TIMEOUT parameter
`timescale 1ns/10ps
`include "gain_link_defines.vh"
module tb_gain_link_matrix;
  localparam N = 6;
  reg [49:0] tx_cap;
  reg clk, nrst, wr_stb, rd_stb, smp_stb;
  reg [3:0] addr;
  reg [31:0] wdata;
  reg [N*24-1:0] chan_gr;
  reg [47:0] peer_pub_in;
  wire [31:0] rdata;
  wire [N*24-1:0] smooth_gr;
  wire smooth_stb, link_clk, link_rx, link_tx;
  wire [1:0] pub_use;
  integer fails, total_checks;
  gain_link_matrix #(.NCH(N), .W(24), .TIMEOUT(64)) dut (.clk(clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .smp_stb(smp_stb),
    .chan_gr(chan_gr), .peer_pub_in(peer_pub_in), .smooth_gr(smooth_gr),
    .smooth_stb(smooth_stb), .pub_use(pub_use), .link_clk(link_clk), .link_rx(link_rx),
    .link_tx(link_tx));
  peer_link_model u_peer (.link_clk(link_clk), .link_rx(link_rx));
  // Far end samples the serial output on the link clock rise
  always @(posedge link_clk)
    tx_cap <= {tx_cap[48:0], link_tx};
  ////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task close_out;
    begin
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp, input string nm);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp)
      begin
        fails = fails + 1;
        $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      wr_stb <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_stb <= 1'b0;
    end
  endtask
  // Read data stands only in the cycle after the strobe
  task rdchk(input [3:0] a, input [31:0] exp);
    begin
      @(posedge clk);
      rd_stb <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1 chk(rdata, exp, "rdata");
    end
  endtask
  // One sample, bounded wait for the answer, then compare every channel
  task smp(input [N*24-1:0] gr, input [N*24-1:0] exp);
    integer k;
    begin
      @(posedge clk);
      smp_stb <= 1'b1;
      chan_gr <= gr;
      @(posedge clk);
      smp_stb <= 1'b0;
      #1 k = 0;
      while (smooth_stb !== 1'b1 && k < 8)
      begin
        @(posedge clk);
        #1 k = k + 1;
      end
      if (k == 8)
      begin
        fails = fails + 1;
        close_out;
      end
      else
        for (k = 0; k < N; k = k + 1)
          chk({8'h00, smooth_gr[k*24 +: 24]}, {8'h00, exp[k*24 +: 24]}, "smooth_gr");
    end
  endtask
  ////////////////////////////////////////////////////////////
  task t_defaults;
    begin
      rdchk(`ADDR_ASSIGN, 32'h0);
      rdchk(`ADDR_CTRL, 32'h0);
      rdchk(`ADDR_PRIV_XLINK, 32'h0);
      wr(4'hf, 32'hffff_ffff);
      rdchk(4'hf, 32'h0);
    end
  endtask
  task t_private;
    begin
      wr(`ADDR_CTRL, 32'h9);
      wr(`ADDR_ASSIGN, 32'h50);
      wr(`ADDR_PRIV_XLINK, 32'h32);
      smp({24'h7, 24'h9, 24'h0, 24'h14, 24'h64, 24'h28},
        {24'h9, 24'h9, 24'h32, 24'h32, 24'h64, 24'h64});
      wr(`ADDR_PRIV_XLINK, 32'h1932);
      smp({24'h7, 24'h9, 24'h0, 24'h320, 24'h64, 24'h28},
        {24'h9, 24'h9, 24'h320, 24'h320, 24'hc8, 24'hc8});
      wr(`ADDR_ASSIGN, 32'h0b);
      smp({24'h7, 24'h9, 24'h50, 24'h64, 24'h320, 24'h28},
        {24'h9, 24'h9, 24'h64, 24'h64, 24'h320, 24'h0});
      wr(`ADDR_CTRL, 32'h0);
      wr(`ADDR_ASSIGN, 32'h0);
      smp({24'h6, 24'h5, 24'h4, 24'h3, 24'h2, 24'h1},
        {24'h6, 24'h5, 24'h4, 24'h3, 24'h2, 24'h1});
    end
  endtask
  task t_public;
    begin
      wr(`ADDR_CTRL, 32'h101);
      smp({24'h7, 24'h9, 24'h40, 24'h30, 24'h20, 24'h10}, {24'h7, 24'h9, {4{24'h1f4}}});
      chk({30'h0, pub_use}, 32'h1, "pub_use");
      rdchk(`ADDR_STATUS, 32'h1);
    end
  endtask
  task t_replay;
    begin
      wr(`ADDR_CTRL, 32'h20101);
      u_peer.send_frame(24'h123456, 24'h10);
      // Output lags the input by one link period: left carries public A, right public B
      chk({7'h0, tx_cap[48:24]}, {8'h0, 24'h1f4}, "link_tx_left");
      chk({8'h0, tx_cap[23:0]}, 32'h0080_0000, "link_tx_right");
      rdchk(`ADDR_STATUS, 32'h5);
      smp({24'h7, 24'h9, 24'h40, 24'h30, 24'h20, 24'h10},
        {24'h7, 24'h9, {4{24'h123456}}});
      // Silence longer than the 64-cycle link timeout drops the replay
      repeat (100) @(posedge clk);
      rdchk(`ADDR_STATUS, 32'h1);
    end
  endtask
  initial
  begin
    fails = 0;
    total_checks = 0;
    nrst = 1'b0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    smp_stb = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    chan_gr = {N*24{1'b0}};
    peer_pub_in = {24'h0, 24'h1f4};
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_defaults;
    t_private;
    t_public;
    t_replay;
    close_out;
  end
endmodule // tb_gain_link_matrix
